// [hw/prio_reg_map.svh]
// Register map, field layout, reset values and timing counts of the priority register
// Behaviour
// - Timer one priority in bits 14..12
// - Compare one priority in bits 10..8
// - Capture one priority in bits 6..4
// - External irq zero priority in bits 2..0
// - Value seven gives highest level seven
// - Value one gives lowest serviced level
// - Value zero disables the source entirely
// - Bits 15,11,7,3 unstored, read zero
// - Reset loads level four into each field
// - Request passes only when enable is one
`ifndef PRIO_REG_MAP_SVH
`define PRIO_REG_MAP_SVH

// ----------------------------------------------------------------
// Addresses and layout
// ----------------------------------------------------------------
`define PRIO_ADDR_W 4
`define PRIO_CTRL0_OFS 4'h0
`define PRIO_ENABLE_OFS 4'h1
`define PRIO_STATUS_OFS 4'h2
`define PRIO_TIMER_LSB 12
`define PRIO_COMPARE_LSB 8
`define PRIO_CAPTURE_LSB 4
`define PRIO_EXTIRQ_LSB 0
`define PRIO_FIELD_MASK 16'h7777
`define PRIO_CTRL0_RESET 16'h4444
`define PRIO_ENABLE_RESET 4'h0
`define PRIO_READ_LATENCY 1

`endif

// [hw/prio_pkg.sv]
// Types shared by the priority register block
package prio_pkg;
   typedef logic [2:0] level_t;
   typedef logic [15:0] word_t;
   typedef enum logic [1:0] {
      SRC_TIMER = 2'h0,
      SRC_COMPARE = 2'h1,
      SRC_CAPTURE = 2'h2,
      SRC_EXTIRQ = 2'h3
   } source_t;
endpackage

// [hw/prio_level_gate.sv]
// Per-source level gate: combines request, enable and stored level
`timescale 1ns/1ps
module prio_level_gate
   import prio_pkg::*;
(
   input wire logic request,
   input wire logic enable,
   input wire level_t level,
   output logic active,
   output level_t effLevel
);
   // Zero level or cleared enable blocks the source
   always_comb begin
      active = request & enable & (level != 3'h0);
      effLevel = active ? level : 3'h0;
   end
endmodule

// [hw/interrupt_priority_reg0.sv]
// Priority register zero with enables, read port and per-source levels
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "prio_reg_map.svh"
module interrupt_priority_reg0
   import prio_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [`PRIO_ADDR_W-1:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   output logic [15:0] regRdData,
   input wire logic [3:0] srcRequest,
   output level_t timer_one_priority,
   output level_t compare_one_priority,
   output level_t capture_one_priority,
   output level_t ext_irq_zero_priority,
   output logic [3:0] srcActive,
   output logic [11:0] srcLevels
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Extracts one three-bit field from the register word
   function automatic level_t field_of(input word_t w, input int lsb);
      field_of = level_t'(w >> lsb);
   endfunction

   // True when a strobe addresses the given register offset
   function automatic logic hits(input logic stb, input logic [`PRIO_ADDR_W-1:0] a,
      input logic [`PRIO_ADDR_W-1:0] ofs);
      hits = stb && (a == ofs);
   endfunction

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   word_t ctrl0_r, ctrl0_nxt;
   logic [3:0] irqEnable_r, irqEnable_nxt;
   logic [15:0] rdData_r, rdData_nxt;
   logic [3:0] srcActiveInt;
   logic timer_one_irq_enable;

   // Write decode; unstored bits are masked off on every write
   always_comb begin
      ctrl0_nxt = ctrl0_r;
      irqEnable_nxt = irqEnable_r;
      if (hits(regWrStb, regAddr, `PRIO_CTRL0_OFS)) begin
         ctrl0_nxt = regWrData & `PRIO_FIELD_MASK;
      end
      if (hits(regWrStb, regAddr, `PRIO_ENABLE_OFS)) begin
         irqEnable_nxt = regWrData[3:0];
      end
      // Reset comes last so that it wins over a write in the same cycle
      if (rst) begin
         ctrl0_nxt = `PRIO_CTRL0_RESET;
         irqEnable_nxt = `PRIO_ENABLE_RESET;
      end
   end

   // Read mux; unmapped offsets and idle cycles give zero, so data stand one cycle only
   always_comb begin
      rdData_nxt = 16'h0000;
      if (regRdStb && !rst) begin
         case (regAddr)
            `PRIO_CTRL0_OFS: rdData_nxt = ctrl0_r & `PRIO_FIELD_MASK;
            `PRIO_ENABLE_OFS: rdData_nxt = {12'h000, irqEnable_r};
            `PRIO_STATUS_OFS: rdData_nxt = {12'h000, srcActiveInt};
            default: rdData_nxt = 16'h0000;
         endcase
      end
   end

   // Registers only
   always_ff @(posedge sys_clk) begin
      ctrl0_r <= ctrl0_nxt;
      irqEnable_r <= irqEnable_nxt;
      rdData_r <= rdData_nxt;
   end

   assign regRdData = rdData_r;

   // Timer one enable is bit 0 of the enable register
   assign timer_one_irq_enable = irqEnable_r[0];

   // ----------------------------------------------------------------
   // Levels toward the arbiter
   // ----------------------------------------------------------------
   // Stored fields are presented continuously
   assign timer_one_priority = field_of(ctrl0_r, `PRIO_TIMER_LSB);
   assign compare_one_priority = field_of(ctrl0_r, `PRIO_COMPARE_LSB);
   assign capture_one_priority = field_of(ctrl0_r, `PRIO_CAPTURE_LSB);
   assign ext_irq_zero_priority = field_of(ctrl0_r, `PRIO_EXTIRQ_LSB);

   // Array form lets the generate loop index the four fields
   level_t lvlArr [4];
   assign lvlArr[0] = timer_one_priority;
   assign lvlArr[1] = compare_one_priority;
   assign lvlArr[2] = capture_one_priority;
   assign lvlArr[3] = ext_irq_zero_priority;

   // One gate per source
   for (genvar g = 0; g < 4; g++) begin : gateGen
      prio_level_gate uGate (
         .request(srcRequest[g]),
         .enable(irqEnable_r[g]),
         .level(lvlArr[g]),
         .active(srcActiveInt[g]),
         .effLevel(srcLevels[3*g +: 3])
      );
   end
   // Status register reads the same active vector
   assign srcActive = srcActiveInt;

   // ----------------------------------------------------------------
   // Checks: reset and storage
   // ----------------------------------------------------------------
   // Reset loads level four into every field
   reset_value_a: assert property (@(posedge sys_clk)
      rst |=> ctrl0_r == 16'h4444)
      else $error("priority fields not four after reset");
   // Reset clears every enable, so nothing reaches the arbiter
   reset_enable_a: assert property (@(posedge sys_clk)
      rst |=> irqEnable_r == 4'h0)
      else $error("enables not cleared after reset");
   // Read data are zero right after reset
   reset_read_a: assert property (@(posedge sys_clk)
      rst |=> regRdData == 16'h0000)
      else $error("read data not zero after reset");
   // Unstored bits never hold a one
   unused_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
      (ctrl0_r & 16'h8888) == 16'h0000)
      else $error("unstored bit holds a one");
   // A write stores the word with the unstored bits dropped
   write_update_a: assert property (@(posedge sys_clk) disable iff (rst)
      regWrStb && regAddr == 4'h0 |=> ctrl0_r == ($past(regWrData) & 16'h7777))
      else $error("write not stored");
   // Without a write or a reset the stored levels hold
   hold_value_a: assert property (@(posedge sys_clk) disable iff (rst)
      !rst && !(regWrStb && regAddr == 4'h0) |=> $stable(ctrl0_r))
      else $error("levels changed without a write");
   // An enable write lands in the enable register
   enable_write_a: assert property (@(posedge sys_clk) disable iff (rst)
      regWrStb && regAddr == 4'h1 |=> irqEnable_r == $past(regWrData[3:0]))
      else $error("enable write not stored");

   // ----------------------------------------------------------------
   // Checks: field placement
   // ----------------------------------------------------------------
   // Timer one takes bits 14 to 12 of the written word
   timer_field_a: assert property (@(posedge sys_clk) disable iff (rst)
      regWrStb && regAddr == 4'h0 |=> timer_one_priority == $past(regWrData[14:12]))
      else $error("timer field misplaced");
   // Compare one takes bits 10 to 8 of the written word
   compare_field_a: assert property (@(posedge sys_clk) disable iff (rst)
      regWrStb && regAddr == 4'h0 |=> compare_one_priority == $past(regWrData[10:8]))
      else $error("compare field misplaced");
   // Capture one takes bits 6 to 4 of the written word
   capture_field_a: assert property (@(posedge sys_clk) disable iff (rst)
      regWrStb && regAddr == 4'h0 |=> capture_one_priority == $past(regWrData[6:4]))
      else $error("capture field misplaced");
   // External irq zero takes bits 2 to 0 of the written word
   extirq_field_a: assert property (@(posedge sys_clk) disable iff (rst)
      regWrStb && regAddr == 4'h0 |=> ext_irq_zero_priority == $past(regWrData[2:0]))
      else $error("external field misplaced");

   // ----------------------------------------------------------------
   // Checks: gating toward the arbiter
   // ----------------------------------------------------------------
   // Level zero blocks the source and its level
   disabled_source_a: assert property (@(posedge sys_clk) disable iff (rst)
      ext_irq_zero_priority == 3'h0 |-> !srcActive[3] && srcLevels[11:9] == 3'h0)
      else $error("disabled source still active");
   // A cleared timer one enable blocks its request
   enable_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
      !timer_one_irq_enable |-> !srcActive[0])
      else $error("request passed without enable");
   // No source is active without both request and enable
   request_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
      (srcActive & ~(srcRequest & irqEnable_r)) == 4'h0)
      else $error("source active without request and enable");
   // Timer one passes its stored level, never below one
   level_pass_a: assert property (@(posedge sys_clk) disable iff (rst)
      srcActive[0] |-> srcLevels[2:0] == timer_one_priority && srcLevels[2:0] >= 3'h1)
      else $error("active level wrong");
   // Compare one passes its stored level unchanged
   compare_pass_a: assert property (@(posedge sys_clk) disable iff (rst)
      srcActive[1] |-> srcLevels[5:3] == compare_one_priority)
      else $error("compare level wrong");
   // Capture one passes its stored level unchanged
   capture_pass_a: assert property (@(posedge sys_clk) disable iff (rst)
      srcActive[2] |-> srcLevels[8:6] == capture_one_priority)
      else $error("capture level wrong");
   // External irq zero passes its stored level unchanged
   extirq_pass_a: assert property (@(posedge sys_clk) disable iff (rst)
      srcActive[3] |-> srcLevels[11:9] == ext_irq_zero_priority)
      else $error("external level wrong");
   // An idle source shows level zero
   idle_level_a: assert property (@(posedge sys_clk) disable iff (rst)
      !srcActive[2] |-> srcLevels[8:6] == 3'h0)
      else $error("idle source shows a level");

   // ----------------------------------------------------------------
   // Checks: read port
   // ----------------------------------------------------------------
   // A read returns the stored word one cycle later
   read_back_a: assert property (@(posedge sys_clk) disable iff (rst)
      regRdStb && regAddr == 4'h0 |=> regRdData == $past(ctrl0_r))
      else $error("read data wrong");
   // Unstored bits read as zero
   read_mask_a: assert property (@(posedge sys_clk) disable iff (rst)
      regRdStb && regAddr == 4'h0 |=> (regRdData & 16'h8888) == 16'h0000)
      else $error("unstored bit reads as one");
   // Status read returns the active vector of the strobe cycle
   status_read_a: assert property (@(posedge sys_clk) disable iff (rst)
      regRdStb && regAddr == 4'h2 |=> regRdData == {12'h000, $past(srcActive)})
      else $error("status read wrong");

   // Main scenarios
   write_seen_c: cover property (@(posedge sys_clk) regWrStb && regAddr == 4'h0);
   read_seen_c: cover property (@(posedge sys_clk) regRdStb && regAddr == 4'h0);
   top_level_c: cover property (@(posedge sys_clk) srcActive[1] && srcLevels[5:3] == 3'h7);
   disabled_c: cover property (@(posedge sys_clk) srcRequest[2] && capture_one_priority == 3'h0);
   mid_level_c: cover property (@(posedge sys_clk) srcActive[3] && srcLevels[11:9] == 3'h3);
endmodule

// [dv/interrupt_priority_reg0_test.sv]
// Self-checking testbench for the interrupt priority register block
`timescale 1ns/1ps
`include "prio_reg_map.svh"
module interrupt_priority_reg0_test
   import prio_pkg::*;
;
   logic sys_clk, rst, regWrStb, regRdStb;
   logic [3:0] regAddr, srcRequest, srcActive;
   word_t regWrData, regRdData, fieldWord;
   level_t tPrio, cPrio, iPrio, ePrio;
   logic [11:0] srcLevels;
   int n_fail, cmp_count;

   interrupt_priority_reg0 uut (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
      .regRdData(regRdData), .srcRequest(srcRequest), .timer_one_priority(tPrio),
      .compare_one_priority(cPrio), .capture_one_priority(iPrio),
      .ext_irq_zero_priority(ePrio), .srcActive(srcActive), .srcLevels(srcLevels));

   // Field outputs packed back into register layout
   assign fieldWord = {1'h0, tPrio, 1'h0, cPrio, 1'h0, iPrio, 1'h0, ePrio};

   // ----------------------------------------------------------------
   // Bus and compare tasks
   // ----------------------------------------------------------------
   task automatic chk(input word_t got, input word_t exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One-cycle write; outputs settled on return
   task automatic wr(input logic [3:0] a, input word_t d);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'h1;
      @(posedge sys_clk);
      regWrStb <= 1'h0;
      #1;
   endtask

   // One-cycle read; data checked in the following cycle only
   task automatic rd(input logic [3:0] a, input word_t e);
      @(posedge sys_clk);
      regAddr <= a;
      regRdStb <= 1'h1;
      @(posedge sys_clk);
      regRdStb <= 1'h0;
      #1;
      chk(regRdData, e);
   endtask

   task automatic test_done();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Clock, watchdog and test sequence
   // ----------------------------------------------------------------
   initial begin
      sys_clk = 1'h0;
      forever #5 sys_clk = ~sys_clk;
   end

   initial begin
      #100000;
      n_fail++;
      test_done();
   end

   initial begin
      rst = 1'h1;
      regWrStb = 1'h0;
      regRdStb = 1'h0;
      regAddr = 4'h0;
      regWrData = 16'h0000;
      srcRequest = 4'hF;
      n_fail = 0;
      cmp_count = 0;
      repeat (20) @(posedge sys_clk);
      rst <= 1'h0;
      #1;
      chk(fieldWord, 16'h4444);
      rd(`PRIO_CTRL0_OFS, 16'h4444);
      rd(`PRIO_ENABLE_OFS, 16'h0000);
      wr(`PRIO_CTRL0_OFS, 16'hFFFF);
      chk(fieldWord, 16'h7777);
      rd(`PRIO_CTRL0_OFS, 16'h7777);
      wr(`PRIO_CTRL0_OFS, 16'h1234);
      chk(fieldWord, 16'h1234);
      wr(`PRIO_CTRL0_OFS, 16'h8888);
      rd(`PRIO_CTRL0_OFS, 16'h0000);
      wr(`PRIO_CTRL0_OFS, 16'h1070);
      wr(`PRIO_ENABLE_OFS, 16'h000F);
      chk({12'h000, srcActive}, 16'h0005);
      chk({4'h0, srcLevels}, 16'h01C1);
      rd(`PRIO_STATUS_OFS, 16'h0005);
      wr(`PRIO_ENABLE_OFS, 16'h000E);
      chk({12'h000, srcActive}, 16'h0004);
      chk({4'h0, srcLevels}, 16'h01C0);
      @(posedge sys_clk);
      srcRequest <= 4'hB;
      #1;
      chk({12'h000, srcActive}, 16'h0000);
      wr(`PRIO_CTRL0_OFS, 16'h2753);
      chk({12'h000, srcActive}, 16'h000A);
      chk({4'h0, srcLevels}, 16'h0638);
      rd(4'hF, 16'h0000);
      @(posedge sys_clk);
      rst <= 1'h1;
      @(posedge sys_clk);
      rst <= 1'h0;
      #1;
      chk(fieldWord, 16'h4444);
      chk({12'h000, srcActive}, 16'h0000);
      rd(`PRIO_CTRL0_OFS, 16'h4444);
      test_done();
   end
endmodule
